// ===== core/asgt_consts.svh
// Register address, field positions and timing counts of the gap timer
`ifndef ASGT_CONSTS_SVH
`define ASGT_CONSTS_SVH
`define ASGT_REG_ADDR     16'hFF6B
`define ASGT_REG_RESET    8'h00
`define ASGT_EN_BIT       7
`define ASGT_CODE_HI      4
`define ASGT_CODE_LO      0
`define ASGT_REG_MASK     8'h9F
`define ASGT_UNIT_CYC     12'h040
`define ASGT_MIN_EXTRA    12'h01C
`define ASGT_MIN_SCK      2
`endif

// ===== core/asgt_pkg.sv
// Types shared by the gap timer files
package asgt_pkg;
  typedef struct packed {
    logic       enable;
    logic [4:0] code;
  } asgt_cfg_t;
  typedef enum logic [1:0] {
    ASGT_IDLE = 2'b00,
    ASGT_MAIN = 2'b01,
    ASGT_SCK  = 2'b11
  } asgt_state_t;
endpackage

// ===== core/asgt_sck_edge.sv
// Three-stage synchroniser and rising-edge detect for the serial clock
`timescale 1ns/1ns
module asgt_sck_edge (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic sck_in,
  output logic      sck_rise
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       seen_q;
  logic       seen_d;
  logic       rise_d;
  logic       rise_q;

  // Level counts once stages two and three agree
  always_comb begin
    sync_d = {sync_q[1:0], sck_in};
    seen_d = seen_q;
    rise_d = 1'b0;
    if (sync_q[1] == sync_q[2]) begin
      seen_d = sync_q[2];
      rise_d = sync_q[2] & ~seen_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
      seen_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      seen_q <= seen_d;
      rise_q <= rise_d;
    end
  end

  assign sck_rise = rise_q;
endmodule

// ===== core/asgt_gap_timer.sv
// Transfer gap timer for the automatic serial transmit/receive function
`timescale 1ns/1ns
`include "asgt_consts.svh"
// Overview of operation
// - Enable clear: no hardware gap inserted
// - Enable set: gap timed from code
// - Gap (n+1)*64 plus 28..36 main clocks
// - Gap never under two serial clocks
// - Counter runs on the main system clock
// - Enabled gap disables busy input control
// - Reset clears the register to zero
module asgt_gap_timer
  import asgt_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              auto_transfer_active_flag,
  input  wire logic              byte_done,
  input  wire logic              sck_in,
  output logic                   sck_hold,
  output logic                   busy_ctrl_disable,
  output logic                   gap_active
);
  logic [7:0]  reg_q;
  logic [7:0]  reg_d;
  asgt_cfg_t   cfg;
  asgt_state_t st_q;
  asgt_state_t st_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [1:0]  sck_cnt_q;
  logic [1:0]  sck_cnt_d;
  logic        hold_q;
  logic        hold_d;
  logic        bdis_q;
  logic        bdis_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        sck_rise;
  logic [11:0] target;
  logic        start_ok;
  logic [11:0] len_q;
  logic [11:0] len_d;
  logic [1:0]  rise_cnt_q;
  logic [1:0]  rise_cnt_d;

  asgt_sck_edge u_edge (
    .clk      (clk),
    .reset_n  (reset_n),
    .sck_in   (sck_in),
    .sck_rise (sck_rise)
  );

  assign cfg.enable = reg_q[`ASGT_EN_BIT];
  assign cfg.code   = reg_q[`ASGT_CODE_HI:`ASGT_CODE_LO];
  // Main-clock part of the minimum gap; the extra serial edge adds the rest
  // Twelve bits: code 31 needs 2076 cycles, past an 11-bit count
  assign target = ({7'h00, cfg.code} + 12'h001) * `ASGT_UNIT_CYC
                  + `ASGT_MIN_EXTRA;
  // Only bytes of the automatic function open a gap
  assign start_ok = byte_done & auto_transfer_active_flag;

  // Bits 5 and 6 are masked; writes during a transfer are the caller's duty
  always_comb begin
    reg_d = reg_q;
    if (reg_wr && reg_addr == ADDR_W'(`ASGT_REG_ADDR)) begin
      reg_d = reg_wdata & `ASGT_REG_MASK;
    end
    rdata_d = reg_q;
    bdis_d  = cfg.enable;
  end

  // Timer runs on clk, the main system clock
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    sck_cnt_d = sck_cnt_q;
    hold_d    = hold_q;
    case (st_q)
      ASGT_IDLE: begin
        if (start_ok && cfg.enable) begin
          st_d      = ASGT_MAIN;
          cnt_d     = 12'h001;
          sck_cnt_d = 2'h0;
          hold_d    = 1'b1;
        end else begin
          hold_d = 1'b0;
        end
      end
      ASGT_MAIN: begin
        cnt_d = cnt_q + 12'h001;
        if (sck_rise && sck_cnt_q != 2'(`ASGT_MIN_SCK)) begin
          sck_cnt_d = sck_cnt_q + 2'h1;
        end
        if (cnt_q >= target) begin
          st_d = ASGT_SCK;
        end
      end
      ASGT_SCK: begin
        // Ends on a serial edge so the gap spans the fractional part
        if (sck_rise) begin
          if (sck_cnt_q + 2'h1 >= 2'(`ASGT_MIN_SCK)) begin
            st_d   = ASGT_IDLE;
            hold_d = 1'b0;
          end else begin
            sck_cnt_d = sck_cnt_q + 2'h1;
          end
        end
      end
      default: begin
        st_d   = ASGT_IDLE;
        hold_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_q     <= `ASGT_REG_RESET;
      st_q      <= ASGT_IDLE;
      cnt_q     <= 12'h000;
      sck_cnt_q <= 2'h0;
      hold_q    <= 1'b0;
      bdis_q    <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      reg_q     <= reg_d;
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sck_cnt_q <= sck_cnt_d;
      hold_q    <= hold_d;
      bdis_q    <= bdis_d;
      rdata_q   <= rdata_d;
    end
  end

  // Gap length and serial rises, kept for the checks below
  always_comb begin
    len_d      = 12'h000;
    rise_cnt_d = 2'h0;
    if (hold_q) begin
      len_d      = len_q + 12'h001;
      rise_cnt_d = rise_cnt_q;
      if (sck_rise && rise_cnt_q != 2'h3) begin
        rise_cnt_d = rise_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      len_q      <= 12'h000;
      rise_cnt_q <= 2'h0;
    end else begin
      len_q      <= len_d;
      rise_cnt_q <= rise_cnt_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign sck_hold          = hold_q;
  assign busy_ctrl_disable = bdis_q;
  assign gap_active        = hold_q;

  // Checks assume the register is left alone while a gap runs
  a_reset_clears: assert property (
    @(posedge clk)
    $rose(reset_n) |-> reg_q == `ASGT_REG_RESET)
    else $error("register not zero after reset");
  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    reg_q[6:5] == 2'h0)
    else $error("reserved bits set");
  a_busy_disable: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 busy_ctrl_disable == $past(cfg.enable))
    else $error("busy disable does not follow enable");
  a_no_gap_off: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == ASGT_IDLE && byte_done && !cfg.enable) |=> !sck_hold)
    else $error("gap inserted while disabled");
  a_start_gated: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == ASGT_IDLE && byte_done && !auto_transfer_active_flag)
    |=> !sck_hold)
    else $error("gap opened outside automatic transfer");
  sequence s_start;
    st_q == ASGT_IDLE && start_ok && cfg.enable && cfg.code == 5'h00;
  endsequence
  sequence s_gap_end;
    $fell(hold_q);
  endsequence
  a_gap_starts: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_start |=> sck_hold)
    else $error("hold not raised at byte end");
  a_gap_min: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_start |=> sck_hold [*8])
    else $error("gap ended too early");
  a_gap_floor: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_gap_end |-> len_q > target)
    else $error("gap shorter than its main count");
  a_sck_floor: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_gap_end |-> rise_cnt_q >= 2'(`ASGT_MIN_SCK))
    else $error("gap shorter than two serial clocks");
  a_gap_bound: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_start |=> ##[1:93] st_q == ASGT_SCK)
    else $error("main count exceeded its span");
  a_sck_release: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q == ASGT_SCK && hold_q && !sck_rise) |=> sck_hold)
    else $error("hold released without serial edge");
endmodule

// ===== bench/asgt_tb.sv
// Self-checking bench for the transfer gap timer
`timescale 1ns/1ns
`include "asgt_consts.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  err_total++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module tb
  import asgt_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        byte_done = 1'b0;
  logic        auto_transfer_active_flag = 1'b0;
  logic        sck_in = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        sck_hold;
  logic        busy_ctrl_disable;
  logic        gap_active;
  int          err_total = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          sck_half = 20;
  int          codes [3] = '{0, 5, 31};
  int          n;

  always #2 clk = ~clk;
  always #(sck_half) sck_in = ~sck_in;

  asgt_gap_timer #(.ADDR_W(16)) asgt_gap_timer_inst (
    .clk                       (clk),
    .reset_n                   (reset_n),
    .reg_addr                  (reg_addr),
    .reg_wr                    (reg_wr),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (reg_rdata),
    .auto_transfer_active_flag (auto_transfer_active_flag),
    .byte_done                 (byte_done),
    .sck_in                    (sck_in),
    .sck_hold                  (sck_hold),
    .busy_ctrl_disable         (busy_ctrl_disable),
    .gap_active                (gap_active)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Generous ceiling: the longest gap is about 2100 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] ex);
    repeat (2) @(posedge clk);
    #1;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask

  // Byte end lags a serial rise, as the last shift edge would
  task automatic gap(input int lo, input int hi);
    int g;
    g = 0;
    @(posedge sck_in);
    repeat (6) @(posedge clk);
    #1;
    auto_transfer_active_flag = 1'b1;
    byte_done = 1'b1;
    @(posedge clk) #1;
    byte_done = 1'b0;
    `CHK("gap_active", (hi != 0), gap_active)
    while (sck_hold === 1'b1 && g < 5000) begin
      @(posedge clk) #1;
      g++;
    end
    `CHK("gap_in_range", 1'b1, (g >= lo && g <= hi))
    `CHK("gap_active", 1'b0, gap_active)
    auto_transfer_active_flag = 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    rd_chk(8'h00);
    `CHK("busy_ctrl_disable", 1'b0, busy_ctrl_disable)
    gap(0, 0);
    wr(16'hFF6A, 8'h80);
    rd_chk(8'h00);
    wr(`ASGT_REG_ADDR, 8'hFF);
    rd_chk(8'h9F);
    `CHK("busy_ctrl_disable", 1'b1, busy_ctrl_disable)
    // Upper bound allows two serial periods plus synchroniser delay
    for (int i = 0; i < 3; i++) begin
      n = codes[i];
      wr(`ASGT_REG_ADDR, 8'h80 | n[7:0]);
      gap((n + 1) * 64 + 28, (n + 1) * 64 + 36 + 23);
    end
    sck_half = 400;
    wr(`ASGT_REG_ADDR, 8'h80);
    gap(2 * 200 - 8, 2 * 200 + 8);
    wr(`ASGT_REG_ADDR, 8'h00);
    rd_chk(8'h00);
    `CHK("busy_ctrl_disable", 1'b0, busy_ctrl_disable)
    gap(0, 0);
    end_sim();
  end
endmodule
